// >>> logic/touch_key_pkg.sv
package touch_key_pkg;
    localparam logic [7:0] ADDR_KEY_LOW = 8'h03;
    localparam logic [7:0] ADDR_KEY_HIGH = 8'h04;
    localparam logic [7:0] ADDR_SLIDER = 8'h05;
    localparam logic [7:0] ADDR_PINS = 8'h06;
    localparam logic [7:0] ADDR_SUBREV = 8'h07;
    localparam logic [7:0] ADDR_CALIBRATE = 8'h0A;
    localparam logic [7:0] ADDR_RESET = 8'h0B;
    localparam logic [7:0] ADDR_SLEEP = 8'h0C;
    localparam logic [7:0] ADDR_BURST = 8'h0D;
    localparam logic [7:0] ADDR_FALL_DRIFT = 8'h0F;
    localparam logic [7:0] ADDR_RISE_DRIFT = 8'h10;
    localparam logic [7:0] ADDR_FILTER = 8'h11;
    localparam logic [7:0] ADDR_RECAL = 8'h12;
    localparam logic [7:0] ADDR_LAST = 8'hFF;
    localparam logic [7:0] RST_SLEEP = 8'h01;
    localparam logic [5:0] RST_BURST = 6'h01;
    localparam logic [6:0] RST_FALL_DRIFT = 7'h14;
    localparam logic [6:0] RST_RISE_DRIFT = 7'h05;
    localparam logic [4:0] RST_FILTER = 5'h03;
    localparam logic [7:0] RST_RECAL = 8'hFF;
    localparam int PIN_LSB = 2;
    localparam int CYCLE_TIME_US = 16000;
    localparam int CLK_MHZ = 50;
    localparam int CYCLE_CLOCKS = CYCLE_TIME_US * CLK_MHZ;
    localparam int UNIT_TIME_MS = 160;
    localparam int CYCLE_TIME_MS = 16;
    localparam logic [3:0] CYCLES_PER_UNIT = 4'(UNIT_TIME_MS / CYCLE_TIME_MS);
    localparam logic [6:0] I2C_ADDR_RST = 7'h0D;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ADDR_ACK = 3'b010,
        BUS_WRITE = 3'b011,
        BUS_WRITE_ACK = 3'b100,
        BUS_READ = 3'b101,
        BUS_READ_ACK = 3'b110
    } bus_state_t;
    typedef enum logic [1:0] {
        RST_NONE = 2'b00,
        RST_WAIT = 2'b01,
        RST_QUIET = 2'b10
    } reset_stage_t;
endpackage

// >>> logic/touch_key_status.sv
// Function
// RQ1 - Key detect bits 0-7 at low byte, 8-15 at high byte, 1 means touched.
// RQ2 - Alert goes low when any status byte changes.
// RQ3 - Slider byte holds the latest full 8-bit slider position.
// RQ4 - Pin byte: input pins 3..1 in bits 4..2, all else 0.
// RQ5 - Input pins sampled once per acquisition cycle, nominally every 16 ms.
// RQ6 - Non-zero write to calibrate register recalibrates every enabled key.
// RQ7 - Non-zero write to reset register resets all settings to defaults.
// RQ8 - After reset command: stop acking, release alert, reset ~16 ms later.
// RQ9 - Sleep values 1-255 idle value times 16 ms between acquisitions.
// RQ10 - Sleep value zero stops all measurements.
// RQ11 - Sleep interval register holds 1 after reset.
// RQ12 - Bursts repeat the configured 1-63 times and average; top bits zero.
// RQ13 - References drift only when undetected and not past threshold.
// RQ14 - Separate 7-bit falling and rising drift rates in 0.16 s units.
// RQ15 - Drift rate zero disables tracking in that direction only.
// RQ16 - Falling drift resets to 20, rising drift resets to 5.
// RQ17 - Threshold and hysteresis levels follow the current reference.
// RQ18 - Per-key counter counts successive hits, clears on miss, touch at limit.
// RQ19 - Needed hits are 5-bit filter setting plus one; reset value 3.
// RQ20 - Detection outlasting recal delay recalibrates the key; 0 disables. Code never recalibrates at 255, as age stops at 255.
// RQ21 - Recalibration delay in 0.16 s units, reset value 255.
// RQ22 - Host should keep drift periods above four sleep intervals.
// RQ23 - Alert stays until every changed status byte has been read.
// RQ24 - Register pointer advances by one after each data byte.
// RQ25 - Recalibration loads reference from signal, clears counter and detect.
`timescale 1ns/1ps
`default_nettype none
module touch_key_status
    import touch_key_pkg::*;
#(
    parameter int NUM_KEYS = 16,
    parameter int SIGNAL_WIDTH = 16,
    parameter int CYCLE_TICKS = CYCLE_CLOCKS,
    parameter logic [6:0] BUS_ADDRESS = I2C_ADDR_RST,
    parameter logic [SIGNAL_WIDTH-1:0] NEG_THRESHOLD = 16'h000A,
    parameter logic [SIGNAL_WIDTH-1:0] NEG_HYSTERESIS = 16'h0008,
    parameter logic [7:0] SUB_REVISION = 8'h5A // Arbitrary value
) (
    input wire logic clk, // 50 MHz clock
    input wire logic reset, // Synchronous, active high
    input wire logic scl, // Bus clock level
    input wire logic sdaIn, // Bus data level seen on the wire
    output logic sdaOut, // Bus data drive value, always low
    output logic sdaOe_n, // Low while pulling bus data low
    output logic changeOut, // Alert drive value, always low
    output logic changeOe_n, // Low while alert is asserted
    output logic acquireStart, // Pulse: start one acquisition
    output logic [5:0] burstRepeat, // Bursts to average per acquisition
    input wire logic acquireDone, // Pulse: keySignals valid
    input wire logic [NUM_KEYS*SIGNAL_WIDTH-1:0] keySignals, // Averaged signals
    input wire logic [NUM_KEYS-1:0] keyEnabled, // Enabled keys
    input wire logic sliderValid, // Pulse: new slider position
    input wire logic [7:0] sliderPosIn, // Computed slider position
    input wire logic [2:0] pinLevels, // Levels of general pins 3..1
    input wire logic [2:0] pinIsOutput // Pin 3..1 configured as output
);
    logic softReset;
    reset_stage_t resetStage;
    logic [31:0] tickCnt;
    logic cycleTick;
    logic [3:0] unitCnt;
    logic unitTick;
    logic [7:0] sleepCnt;
    logic [7:0] calibrate, resetReg, sleepInterval, autoRecalDelay;
    logic [5:0] burstRepeatSetting;
    logic [6:0] fallingDrift, risingDrift;
    logic [4:0] filterLimit;
    logic wrStrobe, rdStrobe;
    logic [7:0] wrAddr, wrData, rdAddr;
    logic [NUM_KEYS-1:0] keyDetect;
    logic [7:0] sliderPosition, pinStatus;
    logic [6:0] fallCnt, riseCnt;
    logic fallStep, riseStep;
    logic calPending;
    logic [31:0] readSnap;
    logic [3:0] changed;
    logic alert;

    // Reset command quiets the bus, then resets everything one tick later
    assign softReset = reset || (resetStage == RST_QUIET && cycleTick); // [RQ7]

    always_ff @(posedge clk) begin
        if (softReset) begin
            resetStage <= RST_NONE;
        end else if (wrStrobe && wrAddr == ADDR_RESET && wrData != 8'h00) begin
            resetStage <= RST_WAIT; // [RQ8]
        end else if (resetStage == RST_WAIT && cycleTick) begin
            resetStage <= RST_QUIET; // [RQ8]
        end
    end

    always_ff @(posedge clk) begin
        if (softReset || cycleTick) begin
            tickCnt <= 32'h0;
        end else begin
            tickCnt <= tickCnt + 32'h1;
        end
    end
    assign cycleTick = (tickCnt == 32'(CYCLE_TICKS - 1));

    always_ff @(posedge clk) begin
        if (softReset || unitTick) begin
            unitCnt <= 4'h0;
        end else if (cycleTick) begin
            unitCnt <= unitCnt + 4'h1;
        end
    end
    assign unitTick = cycleTick && (unitCnt == CYCLES_PER_UNIT - 4'h1);

    // Acquisition scheduling
    always_ff @(posedge clk) begin
        if (softReset) begin
            sleepCnt <= 8'h0;
            acquireStart <= 1'b0;
        end else begin
            acquireStart <= 1'b0;
            if (cycleTick && sleepInterval != 8'h00) begin // [RQ10]
                if (sleepCnt + 8'h1 >= sleepInterval) begin // [RQ9]
                    sleepCnt <= 8'h0;
                    acquireStart <= 1'b1;
                end else begin
                    sleepCnt <= sleepCnt + 8'h1;
                end
            end
        end
    end
    assign burstRepeat = burstRepeatSetting; // [RQ12]

    // Software registers
    always_ff @(posedge clk) begin
        if (softReset) begin
            calibrate <= 8'h00;
            resetReg <= 8'h00;
            sleepInterval <= RST_SLEEP; // [RQ11]
            burstRepeatSetting <= RST_BURST;
            fallingDrift <= RST_FALL_DRIFT; // [RQ16]
            risingDrift <= RST_RISE_DRIFT; // [RQ16]
            filterLimit <= RST_FILTER; // [RQ19]
            autoRecalDelay <= RST_RECAL; // [RQ21]
        end else if (wrStrobe) begin
            unique case (wrAddr)
                ADDR_CALIBRATE: calibrate <= wrData;
                ADDR_RESET: resetReg <= wrData;
                ADDR_SLEEP: sleepInterval <= wrData;
                ADDR_BURST: burstRepeatSetting <= wrData[5:0]; // [RQ12]
                ADDR_FALL_DRIFT: fallingDrift <= wrData[6:0]; // [RQ14]
                ADDR_RISE_DRIFT: risingDrift <= wrData[6:0]; // [RQ14]
                ADDR_FILTER: filterLimit <= wrData[4:0]; // [RQ19]
                ADDR_RECAL: autoRecalDelay <= wrData;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (softReset) begin
            calPending <= 1'b0;
        end else if (wrStrobe && wrAddr == ADDR_CALIBRATE && wrData != 8'h00) begin
            calPending <= 1'b1; // [RQ6]
        end else if (acquireDone) begin
            calPending <= 1'b0;
        end
    end

    // Drift step timers, one per direction
    always_ff @(posedge clk) begin
        if (softReset || fallStep) begin
            fallCnt <= 7'h0;
        end else if (unitTick) begin
            fallCnt <= fallCnt + 7'h1;
        end
    end
    assign fallStep = unitTick && fallingDrift != 7'h0 && // [RQ15]
        fallCnt + 7'h1 >= fallingDrift; // [RQ14]

    always_ff @(posedge clk) begin
        if (softReset || riseStep) begin
            riseCnt <= 7'h0;
        end else if (unitTick) begin
            riseCnt <= riseCnt + 7'h1;
        end
    end
    assign riseStep = unitTick && risingDrift != 7'h0 && // [RQ15]
        riseCnt + 7'h1 >= risingDrift; // [RQ14]

    // Per-key detection, drift and recalibration
    for (genvar k = 0; k < NUM_KEYS; k++) begin : g_key
        logic [SIGNAL_WIDTH-1:0] sig, lastSig, reference;
        logic [SIGNAL_WIDTH:0] thrLevel, hystLevel;
        logic [5:0] filterCnt;
        logic [7:0] age;
        logic hit, hold, recal;
        assign sig = keySignals[k*SIGNAL_WIDTH +: SIGNAL_WIDTH];
        // Levels sit below the reference and move with it
        assign thrLevel = {1'b0, sig} + {1'b0, NEG_THRESHOLD}; // [RQ17]
        assign hystLevel = {1'b0, sig} + {1'b0, NEG_HYSTERESIS}; // [RQ17]
        assign hit = thrLevel <= {1'b0, reference};
        assign hold = hystLevel <= {1'b0, reference};
        assign recal = (acquireDone && calPending && keyEnabled[k]) || // [RQ6]
            (autoRecalDelay != 8'h00 && keyDetect[k] && // [RQ20]
             age > autoRecalDelay); // [RQ21]

        always_ff @(posedge clk) begin
            if (softReset) begin
                reference <= '0;
                lastSig <= '0;
                filterCnt <= 6'h0;
                keyDetect[k] <= 1'b0;
            end else if (recal) begin
                reference <= acquireDone ? sig : lastSig; // [RQ25]
                filterCnt <= 6'h0; // [RQ25]
                keyDetect[k] <= 1'b0; // [RQ25]
            end else if (acquireDone) begin
                lastSig <= sig;
                if (!keyEnabled[k]) begin
                    filterCnt <= 6'h0;
                    keyDetect[k] <= 1'b0; // [RQ1]
                end else if (keyDetect[k]) begin
                    keyDetect[k] <= hold;
                    filterCnt <= 6'h0;
                end else if (hit) begin
                    if (filterCnt + 6'h1 >= {1'b0, filterLimit} + 6'h1) begin
                        keyDetect[k] <= 1'b1; // [RQ18] [RQ19]
                        filterCnt <= 6'h0;
                    end else begin
                        filterCnt <= filterCnt + 6'h1; // [RQ18]
                    end
                end else begin
                    filterCnt <= 6'h0; // [RQ18]
                end
            end else if (!keyDetect[k] && filterCnt == 6'h0) begin
                // Tracking frozen while detected or past threshold
                if (fallStep && lastSig < reference) begin // [RQ13]
                    reference <= reference - 1'b1;
                end else if (riseStep && lastSig > reference) begin // [RQ13]
                    reference <= reference + 1'b1;
                end
            end
        end

        always_ff @(posedge clk) begin
            if (softReset || !keyDetect[k] || recal) begin
                age <= 8'h0;
            end else if (unitTick && age != 8'hFF) begin
                age <= age + 8'h1; // [RQ20]
            end
        end
    end

    // Slider and pin status
    always_ff @(posedge clk) begin
        if (softReset) begin
            sliderPosition <= 8'h00;
        end else if (sliderValid) begin
            sliderPosition <= sliderPosIn; // [RQ3]
        end
    end

    always_ff @(posedge clk) begin
        if (softReset) begin
            pinStatus <= 8'h00;
        end else if (acquireStart) begin
            pinStatus <= 8'({pinLevels & ~pinIsOutput} << PIN_LSB); // [RQ4] [RQ5]
        end
    end

    function automatic logic [7:0] readByte(input logic [7:0] a);
        unique case (a)
            ADDR_KEY_LOW: readByte = keyDetect[7:0]; // [RQ1]
            ADDR_KEY_HIGH: readByte = keyDetect[15:8]; // [RQ1]
            ADDR_SLIDER: readByte = sliderPosition;
            ADDR_PINS: readByte = pinStatus;
            ADDR_SUBREV: readByte = SUB_REVISION;
            ADDR_CALIBRATE: readByte = calibrate;
            ADDR_RESET: readByte = resetReg;
            ADDR_SLEEP: readByte = sleepInterval;
            ADDR_BURST: readByte = {2'b00, burstRepeatSetting}; // [RQ12]
            ADDR_FALL_DRIFT: readByte = {1'b0, fallingDrift}; // [RQ14]
            ADDR_RISE_DRIFT: readByte = {1'b0, risingDrift}; // [RQ14]
            ADDR_FILTER: readByte = {3'b000, filterLimit}; // [RQ19]
            ADDR_RECAL: readByte = autoRecalDelay;
            default: readByte = 8'h00;
        endcase
    endfunction

    // Alert tracking: each status byte compared with its last read value
    always_ff @(posedge clk) begin
        if (softReset) begin
            readSnap <= 32'h0;
        end else if (rdStrobe && rdAddr >= ADDR_KEY_LOW && rdAddr <= ADDR_PINS) begin
            readSnap[(rdAddr - ADDR_KEY_LOW)*8 +: 8] <= readByte(rdAddr); // [RQ23]
        end
    end
    for (genvar b = 0; b < 4; b++) begin : g_change
        assign changed[b] = readByte(ADDR_KEY_LOW + 8'(b)) != readSnap[b*8 +: 8]; // [RQ2]
    end

    always_ff @(posedge clk) begin
        if (softReset || resetStage == RST_QUIET) begin
            alert <= 1'b0; // [RQ8]
        end else begin
            alert <= |changed; // [RQ2] [RQ23]
        end
    end
    assign changeOut = 1'b0;
    assign changeOe_n = ~alert;

    // Bus slave
    bus_state_t busState;
    logic sclPrev, sdaPrev, sdaLow, isRead, ptrLoaded;
    logic [3:0] bitCnt;
    logic [7:0] shiftIn, shiftOut, ptr;
    wire logic sclRise = scl && !sclPrev;
    wire logic sclFall = !scl && sclPrev;
    wire logic busStart = scl && sclPrev && sdaPrev && !sdaIn;
    wire logic busStop = scl && sclPrev && !sdaPrev && sdaIn;

    always_ff @(posedge clk) begin
        if (softReset) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= scl;
            sdaPrev <= sdaIn;
        end
    end

    always_ff @(posedge clk) begin
        if (softReset) begin
            busState <= BUS_IDLE;
            sdaLow <= 1'b0;
            isRead <= 1'b0;
            ptrLoaded <= 1'b0;
            bitCnt <= 4'h0;
            shiftIn <= 8'h00;
            shiftOut <= 8'h00;
            ptr <= 8'h00;
            wrStrobe <= 1'b0;
            wrAddr <= 8'h00;
            wrData <= 8'h00;
            rdStrobe <= 1'b0;
            rdAddr <= 8'h00;
        end else begin
            wrStrobe <= 1'b0;
            rdStrobe <= 1'b0;
            if (busStart) begin
                busState <= BUS_ADDR;
                bitCnt <= 4'h0;
                sdaLow <= 1'b0;
            end else if (busStop) begin
                busState <= BUS_IDLE;
                sdaLow <= 1'b0;
            end else begin
                unique case (busState)
                    BUS_IDLE: ;
                    BUS_ADDR, BUS_WRITE: begin
                        if (sclRise) begin
                            shiftIn <= {shiftIn[6:0], sdaIn};
                            bitCnt <= bitCnt + 4'h1;
                        end else if (sclFall && bitCnt == BITS_PER_BYTE) begin
                            bitCnt <= 4'h0;
                            if (busState == BUS_ADDR) begin
                                if (shiftIn[7:1] == BUS_ADDRESS &&
                                    resetStage != RST_QUIET) begin // [RQ8]
                                    busState <= BUS_ADDR_ACK;
                                    sdaLow <= 1'b1;
                                    isRead <= shiftIn[0];
                                    ptrLoaded <= 1'b0;
                                end else begin
                                    busState <= BUS_IDLE;
                                end
                            end else begin
                                busState <= BUS_WRITE_ACK;
                                sdaLow <= 1'b1;
                                ptrLoaded <= 1'b1;
                                if (!ptrLoaded) begin
                                    ptr <= shiftIn;
                                end else begin
                                    wrStrobe <= 1'b1;
                                    wrAddr <= ptr;
                                    wrData <= shiftIn;
                                    if (ptr != ADDR_LAST) begin
                                        ptr <= ptr + 8'h1; // [RQ24]
                                    end
                                end
                            end
                        end
                    end
                    BUS_ADDR_ACK, BUS_WRITE_ACK, BUS_READ_ACK: begin
                        if (busState == BUS_READ_ACK && sclRise && sdaIn) begin
                            busState <= BUS_IDLE;
                        end else if (sclFall) begin
                            bitCnt <= 4'h0;
                            if (isRead) begin
                                busState <= BUS_READ;
                                shiftOut <= readByte(ptr);
                                sdaLow <= ~|(readByte(ptr) & 8'h80);
                            end else begin
                                busState <= BUS_WRITE;
                                sdaLow <= 1'b0;
                            end
                        end
                    end
                    BUS_READ: begin
                        if (sclFall) begin
                            bitCnt <= bitCnt + 4'h1;
                            shiftOut <= {shiftOut[6:0], 1'b0};
                            if (bitCnt == BITS_PER_BYTE - 4'h1) begin
                                busState <= BUS_READ_ACK;
                                sdaLow <= 1'b0;
                                rdStrobe <= 1'b1;
                                rdAddr <= ptr;
                                if (ptr != ADDR_LAST) begin
                                    ptr <= ptr + 8'h1; // [RQ24]
                                end
                            end else begin
                                sdaLow <= ~shiftOut[6];
                            end
                        end
                    end
                    default: busState <= BUS_IDLE;
                endcase
            end
        end
    end
    assign sdaOut = 1'b0;
    assign sdaOe_n = ~sdaLow;
endmodule
`default_nettype wire

// >>> tb/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
    parameter logic [6:0] DEV = 7'h0D
) (
    input wire logic clk, // System clock
    input wire logic sdaLine, // Resolved data wire
    output logic scl, // Bus clock
    output logic sdaOe_n // Low while host pulls data low
);
    initial begin
        scl = 1'b1;
        sdaOe_n = 1'b1;
    end
    task half();
        repeat (4) @(negedge clk);
    endtask
    task bitIo(input logic b, output logic r);
        sdaOe_n = b;
        half();
        scl = 1'b1;
        half();
        r = sdaLine;
        scl = 1'b0;
        half();
    endtask
    // Eight data bits, then the ack slot
    task byteIo(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) bitIo(d[i], q[i]);
    endtask
    task start();
        sdaOe_n = 1'b1;
        scl = 1'b1;
        half();
        sdaOe_n = 1'b0;
        half();
        scl = 1'b0;
        half();
    endtask
    task stop();
        sdaOe_n = 1'b0;
        half();
        scl = 1'b1;
        half();
        sdaOe_n = 1'b1;
        half();
    endtask
    task wr(input logic [7:0] p, input logic [15:0] d, input int n);
        logic [8:0] q;
        start();
        byteIo({DEV, 1'b0, 1'b1}, q);
        byteIo({p, 1'b1}, q);
        for (int i = 0; i < n; i++) byteIo({d[15-8*i -: 8], 1'b1}, q);
        stop();
    endtask
    // Reads two bytes from p
    task rd(input logic [7:0] p, output logic [15:0] v,
        output logic ok);
        logic [8:0] q;
        start();
        byteIo({DEV, 1'b0, 1'b1}, q);
        ok = !q[0];
        byteIo({p, 1'b1}, q);
        stop();
        start();
        byteIo({DEV, 1'b1, 1'b1}, q);
        byteIo(9'h1FE, q);
        v[15:8] = q[8:1];
        byteIo(9'h1FF, q);
        v[7:0] = q[8:1];
        stop();
    endtask
endmodule
`default_nettype wire

// >>> tb/test_touch_key_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_touch_key_status;
    import touch_key_pkg::*;
    localparam int TICKS = 400;
    logic clk, reset, scl, hostOe_n, sdaOut, sdaOe_n, changeOut, changeOe_n;
    logic acquireStart, acquireDone, sliderValid, ok;
    logic [5:0] burstRepeat;
    logic [255:0] keySignals;
    logic [15:0] keyEnabled, v;
    logic [7:0] sliderPosIn;
    logic [2:0] pinLevels, pinIsOutput;
    int nErrors = 0, cmpCount = 0, n;
    wire logic sda = sdaOe_n & hostOe_n;
    touch_key_status #(.CYCLE_TICKS(TICKS), .SUB_REVISION(8'h3C))
    u_touch_key_status (.clk(clk), .reset(reset), .scl(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .changeOut(changeOut),
        .changeOe_n(changeOe_n), .acquireStart(acquireStart),
        .burstRepeat(burstRepeat), .acquireDone(acquireDone),
        .keySignals(keySignals), .keyEnabled(keyEnabled),
        .sliderValid(sliderValid), .sliderPosIn(sliderPosIn),
        .pinLevels(pinLevels), .pinIsOutput(pinIsOutput));
    i2c_host_model u_i2c_host_model (.clk(clk), .sdaLine(sda), .scl(scl),
        .sdaOe_n(hostOe_n));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rdChk(input logic [7:0] p, input logic [15:0] e);
        u_i2c_host_model.rd(p, v, ok);
        chk(v, e);
    endtask
    task gap(output int c);
        c = 1;
        @(negedge clk);
        while (acquireStart !== 1'b1 && c < 3000) begin
            @(negedge clk);
            c++;
        end
    endtask
    task acq();
        gap(n);
        acquireDone = 1'b1;
        @(negedge clk);
        acquireDone = 1'b0;
    endtask
    task slide(input logic [7:0] p);
        sliderPosIn = p;
        sliderValid = 1'b1;
        @(negedge clk);
        sliderValid = 1'b0;
    endtask
    task resetValues();
        rdChk(ADDR_SLEEP, 16'h0101);
        rdChk(ADDR_FALL_DRIFT, 16'h1405);
        rdChk(ADDR_FILTER, 16'h03FF);
    endtask
    task settingsAndSleep();
        u_i2c_host_model.wr(ADDR_SLEEP, 16'h023F, 2);
        chk(16'(burstRepeat), 16'h003F);
        u_i2c_host_model.wr(ADDR_FALL_DRIFT, 16'hFFFF, 2);
        rdChk(ADDR_FALL_DRIFT, 16'h7F7F);
        u_i2c_host_model.wr(ADDR_FILTER, 16'hFF00, 1);
        rdChk(ADDR_FILTER, 16'h1FFF);
        u_i2c_host_model.wr(ADDR_FILTER, 16'h0300, 1);
        gap(n);
        gap(n);
        chk(16'(n), 16'(2 * TICKS));
        u_i2c_host_model.wr(ADDR_SLEEP, 16'h0000, 1);
        gap(n);
        chk(16'(n), 16'(3000));
        u_i2c_host_model.wr(ADDR_SLEEP, 16'h0100, 1);
    endtask
    task pinsAndAlert();
        pinLevels = 3'b101;
        pinIsOutput = 3'b010;
        acq();
        repeat (3) @(negedge clk);
        chk(16'(changeOe_n), 16'h0000);
        rdChk(ADDR_PINS, 16'h143C);
        chk(16'(changeOe_n), 16'h0001);
    endtask
    task keyFilter();
        u_i2c_host_model.wr(ADDR_CALIBRATE, 16'h0100, 1);
        acq();
        keySignals[15:0] = 16'h03DE;
        keySignals[159:144] = 16'h03DE;
        repeat (3) acq();
        rdChk(ADDR_KEY_LOW, 16'h0000);
        acq();
        rdChk(ADDR_KEY_LOW, 16'h0102);
        u_i2c_host_model.wr(ADDR_CALIBRATE, 16'h0100, 1);
        acq();
        rdChk(ADDR_KEY_LOW, 16'h0000);
    endtask
    task sliderAndReset();
        slide(8'hA7);
        rdChk(ADDR_SLIDER, 16'hA714);
        slide(8'h5B);
        u_i2c_host_model.wr(ADDR_RESET, 16'h0100, 1);
        gap(n);
        repeat (3) @(negedge clk);
        chk(16'(changeOe_n), 16'h0001);
        u_i2c_host_model.rd(ADDR_SLEEP, v, ok);
        chk(16'(ok), 16'h0000);
        repeat (TICKS) @(negedge clk);
        rdChk(ADDR_FALL_DRIFT, 16'h1405);
    endtask
    task finishTest();
        $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        nErrors++;
        finishTest();
    end
    initial begin
        reset = 1'b1;
        acquireDone = 1'b0;
        keySignals = {16{16'h03E8}};
        keyEnabled = 16'hFFFF;
        sliderValid = 1'b0;
        sliderPosIn = 8'h00;
        pinLevels = 3'b000;
        pinIsOutput = 3'b000;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        resetValues();
        settingsAndSleep();
        pinsAndAlert();
        keyFilter();
        sliderAndReset();
        finishTest();
    end
endmodule
`default_nettype wire

// >>> tb/touch_key_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module touch_key_status_assertions
    import touch_key_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic scl, // Bus clock
    input wire logic sdaOut, // Data drive value
    input wire logic sdaOe_n, // Data pulled low
    input wire logic changeOut, // Alert drive value
    input wire logic changeOe_n, // Alert asserted
    input wire logic acquireStart, // Acquisition start
    input wire logic [5:0] burstRepeat, // Burst setting
    input wire logic sliderValid, // New slider value
    input wire logic [7:0] sliderPosIn // Slider value
);
    logic [7:0] shownSlider;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    always_ff @(posedge clk) begin
        if (reset) begin
            shownSlider <= 8'h00;
        end else if (sliderValid) begin
            shownSlider <= sliderPosIn;
        end
    end
    sequence startPulse;
        acquireStart ##1 !acquireStart;
    endsequence
    sequence heldLow;
        !sdaOe_n [*6];
    endsequence
    chk_reset_idle:
    assert property (disable iff (1'b0) reset |=> sdaOe_n && changeOe_n
        && !acquireStart && burstRepeat == 6'h01) else $error("not idle");
    chk_drive_low:
    assert property (sdaOut == 1'b0 && changeOut == 1'b0)
        else $error("pin driven high");
    chk_start_pulse:
    assert property (acquireStart |-> startPulse) else $error("long start");
    chk_burst_nonzero:
    assert property (burstRepeat != 6'h00) else $error("burst count zero");
    chk_burst_on_write:
    assert property (!$stable(burstRepeat) |-> !scl || burstRepeat == 6'h01)
        else $error("burst moved");
    chk_slider_alert:
    assert property (sliderValid && sliderPosIn != shownSlider
        |-> ##[1:3] !changeOe_n) else $error("no slider alert");
    chk_sda_edge:
    assert property (!$stable(sdaOe_n) |-> !scl)
        else $error("data moved, scl high");
    chk_ack_width:
    assert property ($fell(sdaOe_n) |-> heldLow) else $error("short low bit");
endmodule
bind touch_key_status touch_key_status_assertions u_touch_key_status_assertions (
    .clk(clk), .reset(reset), .scl(scl), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .changeOut(changeOut), .changeOe_n(changeOe_n),
    .acquireStart(acquireStart), .burstRepeat(burstRepeat),
    .sliderValid(sliderValid), .sliderPosIn(sliderPosIn)
);
`default_nettype wire
